// *** design/dcr_defines.svh ***
// Purpose: offsets-free constants of the disc controller register interface
// Assumes: accumulator bit 0 is the most significant bit, so field n sits at [15-n]
// Notes: vector ranges below are already converted to verilog bit order
`ifndef DCR_DEFINES_SVH
`define DCR_DEFINES_SVH

// accumulator fields of the command/drive output instruction
`define DCR_AC_CLR_DONE 15
`define DCR_AC_CLR_SEEK 14
`define DCR_AC_CMD 10:7
`define DCR_AC_DRIVE 6:5
`define DCR_AC_AUX 3:0
// cylinder and surface/sector/count fields
`define DCR_AC_CYL 9:0
`define DCR_AC_SURF 14:10
`define DCR_AC_SECT 9:5
`define DCR_AC_CNT 4:0
// controller status word positions
`define DCR_ST_CTL_FULL 15
`define DCR_ST_DONE 14
`define DCR_ST_SEEK_HI 13
`define DCR_ST_ERR_HI 8
`define DCR_ST_CTL_ERR 0
// drive status word positions
`define DCR_DS_RESERVED 14
`define DCR_DS_READY 12
`define DCR_DS_BUSY 11
`define DCR_DS_WPROT 9
`define DCR_DS_ILL_ADDR 7
`define DCR_DS_ILL_CMD 6
`define DCR_DS_FAULT 5:3
`define DCR_DS_ERR 0
// configured capacity
`define DCR_MAX_SURFACE 5'h13
`define DCR_MAX_SECTOR 5'h1F
// timing
`define DCR_CLK_KHZ 50000
`define DCR_XFER_TMO_MS 1000
`define DCR_SEEK_TMO_MS 500
`define DCR_XFER_TMO_CYC (`DCR_XFER_TMO_MS * `DCR_CLK_KHZ)
`define DCR_SEEK_TMO_CYC (`DCR_SEEK_TMO_MS * `DCR_CLK_KHZ)
`define DCR_TMR_W 26
// reset values
`define DCR_RST_WORD 16'h0000

`endif

// *** design/dcr_pkg.sv ***
// Purpose: types shared by the disc controller register interface
// Assumes: nothing
// Notes: command codes follow the 4-bit command field
package dcr_pkg;
   typedef enum logic [3:0] {
      dcr_read = 4'h0, dcr_recal = 4'h1, dcr_seek = 4'h2, dcr_wr_hdr = 4'h3,
      dcr_rd_offp = 4'h4, dcr_rd_offm = 4'h5, dcr_format = 4'h6, dcr_release = 4'h7,
      dcr_trespass = 4'h8, dcr_alt1 = 4'h9, dcr_alt2 = 4'hA, dcr_nop = 4'hB,
      dcr_verify = 4'hC, dcr_rd_fifo = 4'hD, dcr_write = 4'hE, dcr_rd_fmt = 4'hF
   } dcr_cmd_type;

   // gray along idle -> check -> transfer
   typedef enum logic [1:0] {
      dcr_st_idle = 2'b00, dcr_st_check = 2'b01, dcr_st_xfer = 2'b11
   } dcr_state_type;
endpackage

// *** design/dcr_timeout.sv ***
// Purpose: restartable one-shot timeout counter
// Assumes: i_start and i_run are synchronous to i_ref_clk
// Notes: o_expired pulses once when i_run has stayed high for LIMIT cycles
`timescale 1ns/10ps
`include "dcr_defines.svh"
module dcr_timeout #(
   parameter int unsigned LIMIT = 16
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_start,
   input wire logic i_run,
   output logic o_expired
);
   typedef struct packed {
      logic [`DCR_TMR_W-1:0] cnt;
      logic fired;
   } dcr_tmr_type;

   dcr_tmr_type r;
   dcr_tmr_type next_r;

   // counting stops after firing so a stuck run level gives only one pulse
   always_comb begin
      next_r = r;
      if (i_start || !i_run) begin
         next_r.cnt = '0;
         next_r.fired = 1'b0;
      end else if (!r.fired) begin
         if (r.cnt == `DCR_TMR_W'(LIMIT - 1)) begin
            next_r.fired = 1'b1;
         end
         next_r.cnt = r.cnt + `DCR_TMR_W'(1);
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign o_expired = i_run && !i_start && !r.fired && (r.cnt == `DCR_TMR_W'(LIMIT - 1));
endmodule // dcr_timeout

// *** design/dcr_io_regs.sv ***
// Purpose: programmed-I/O register interface of a moving-head disc controller
// Assumes: instruction strobes are one-cycle pulses synchronous to i_ref_clk
// Notes: sector engine, DMA path and drive cable sit outside; they report events here
`timescale 1ns/10ps
`include "dcr_defines.svh"
module dcr_io_regs #(
   parameter int unsigned XFER_TMO_CYC = `DCR_XFER_TMO_CYC,
   parameter int unsigned SEEK_TMO_CYC = `DCR_SEEK_TMO_CYC
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic [15:0] i_accumulator,
   input wire logic i_out_cmd_drive_instr,
   input wire logic i_out_mem_addr_instr,
   input wire logic i_out_cyl_or_sector_instr,
   input wire logic i_io_pulse_control,
   input wire logic i_io_start_control,
   input wire logic i_in_ctrl_status_instr,
   input wire logic i_in_drive_status_instr,
   input wire logic i_in_sector_position_instr,
   input wire logic i_drv_cmd_taken,
   input wire logic [3:0] i_drv_seek_done,
   input wire logic i_drv_reserved,
   input wire logic i_drv_ready,
   input wire logic i_drv_busy,
   input wire logic i_drv_wprot,
   input wire logic [2:0] i_drv_fault,
   input wire logic i_drv_cyl_illegal,
   input wire logic i_drv_seek_error,
   input wire logic i_sector_done,
   input wire logic i_ecc_error,
   input wire logic i_verify_mismatch,
   input wire logic i_bad_sector,
   input wire logic i_hdr_cyl_mismatch,
   input wire logic i_hdr_surf_mismatch,
   input wire logic i_fifo_late,
   input wire logic [31:0] i_ecc_residue,
   output logic [15:0] o_data_in,
   output logic o_busy,
   output logic o_done,
   output logic o_control_full,
   output logic [3:0] o_command,
   output logic [1:0] o_drive_sel,
   output logic [15:0] o_dma_addr,
   output logic [3:0] o_upper_address_bits,
   output logic [9:0] o_cylinder,
   output logic [4:0] o_surface,
   output logic [4:0] o_sector,
   output logic [4:0] o_count,
   output logic o_drv_cmd_start,
   output logic o_xfer_abort,
   output logic o_ecc_retry,
   output logic o_fault_clear,
   output logic o_recalibrate
);
   typedef struct packed {
      dcr_pkg::dcr_state_type state;
      dcr_pkg::dcr_cmd_type cmd;
      logic [1:0] drive_sel;
      logic [3:0] aux;
      logic [15:0] dma_addr;
      logic [3:0] ext_addr;
      logic [9:0] cyl;
      logic [4:0] surf;
      logic [4:0] sect;
      logic [4:0] cnt;
      logic ctl_full;
      logic done;
      logic [3:0] seek_done;
      logic [7:0] err;      // index 0 is status bit 8, index 7 is bit 1
      logic fault_lat;
      logic ill_addr;
      logic ill_cmd;
      logic retried;
      logic seek_run;
      logic [15:0] data_in;
      logic drv_start;
      logic abort;
      logic retry;
      logic fault_clr;
      logic recal;
   } dcr_io_type;

   dcr_io_type r;
   dcr_io_type next_r;
   logic xfer_tmo;
   logic seek_tmo;
   logic start_ok;
   logic seek_go;

   // commands that move sector data and so make the controller busy
   function automatic logic is_data_cmd(input dcr_pkg::dcr_cmd_type c);
      is_data_cmd = !(c inside {dcr_pkg::dcr_recal, dcr_pkg::dcr_seek, dcr_pkg::dcr_release,
         dcr_pkg::dcr_trespass, dcr_pkg::dcr_alt1, dcr_pkg::dcr_alt2, dcr_pkg::dcr_nop});
   endfunction

   // only reads, plain or offset, get the single ECC retry
   function automatic logic is_read_cmd(input dcr_pkg::dcr_cmd_type c);
      is_read_cmd = c inside {dcr_pkg::dcr_read, dcr_pkg::dcr_rd_offp, dcr_pkg::dcr_rd_offm};
   endfunction

   // normal controller status word
   function automatic logic [15:0] ctl_word(input dcr_io_type s, input logic [2:0] flt);
      logic [15:0] w;
      w = `DCR_RST_WORD;
      w[`DCR_ST_CTL_FULL] = s.ctl_full;
      w[`DCR_ST_DONE] = s.done;
      for (int d = 0; d < 4; d++) begin
         w[`DCR_ST_SEEK_HI - d] = s.seek_done[d];
      end
      for (int e = 0; e < 8; e++) begin
         w[`DCR_ST_ERR_HI - e] = s.err[e];
      end
      w[`DCR_ST_CTL_ERR] = (|s.err) || s.fault_lat || (|flt);
      ctl_word = w;
   endfunction

   assign o_busy = (r.state != dcr_pkg::dcr_st_idle);
   assign start_ok = i_io_start_control && !o_busy && is_data_cmd(r.cmd);
   assign seek_go = i_out_cyl_or_sector_instr && i_io_pulse_control && !r.ctl_full
      && (r.cmd == dcr_pkg::dcr_seek) && !i_drv_busy;

   // transfer watchdog, restarted by every accepted start
   dcr_timeout #(.LIMIT(XFER_TMO_CYC)) u_xfer_tmo (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_start(start_ok),
      .i_run(o_busy),
      .o_expired(xfer_tmo)
   );

   // seek watchdog, runs from command start until the drive reports done
   dcr_timeout #(.LIMIT(SEEK_TMO_CYC)) u_seek_tmo (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_start(seek_go),
      .i_run(r.seek_run),
      .o_expired(seek_tmo)
   );

   // next state: clears first, sets later so a simultaneous event wins, except control full and seek_run, where the drive-taken or bad-cylinder clear wins
   always_comb begin
      logic fin;
      logic adv;
      fin = 1'b0;
      adv = 1'b0;
      next_r = r;
      next_r.drv_start = 1'b0;
      next_r.abort = 1'b0;
      next_r.retry = 1'b0;
      next_r.fault_clr = 1'b0;
      next_r.recal = 1'b0;
      // command and drive select; locked out while a drive command is pending
      if (i_out_cmd_drive_instr && !r.ctl_full) begin
         if (i_accumulator[`DCR_AC_CLR_DONE]) begin
            next_r.done = 1'b0;
         end
         for (int d = 0; d < 4; d++) begin
            if (i_accumulator[`DCR_AC_CLR_SEEK - d]) begin
               next_r.seek_done[d] = 1'b0;
            end
         end
         next_r.cmd = dcr_pkg::dcr_cmd_type'(i_accumulator[`DCR_AC_CMD]);
         next_r.drive_sel = i_accumulator[`DCR_AC_DRIVE];
         next_r.aux = i_accumulator[`DCR_AC_AUX];
         next_r.ill_addr = 1'b0;
         next_r.ill_cmd = 1'b0;
      end
      // memory address load
      if (i_out_mem_addr_instr && !o_busy) begin
         next_r.dma_addr = i_accumulator;
         next_r.ext_addr = r.aux;
      end
      // cylinder or surface/sector/count load, chosen by the held command
      if (i_out_cyl_or_sector_instr) begin
         if (r.cmd == dcr_pkg::dcr_seek) begin
            if (!r.ctl_full) begin
               next_r.cyl = i_accumulator[`DCR_AC_CYL];
            end
         end else if (!o_busy) begin
            next_r.surf = i_accumulator[`DCR_AC_SURF];
            next_r.sect = i_accumulator[`DCR_AC_SECT];
            next_r.cnt = i_accumulator[`DCR_AC_CNT];
         end
         if (i_io_pulse_control && !r.ctl_full) begin
            next_r.ctl_full = 1'b1;
            next_r.drv_start = 1'b1;
            if (r.cmd == dcr_pkg::dcr_seek && i_drv_busy) begin
               next_r.ill_cmd = 1'b1;
            end
         end
      end
      if (i_drv_cmd_taken) begin
         next_r.ctl_full = 1'b0;
      end
      if (seek_go) begin
         next_r.seek_run = 1'b1;
      end else if (i_drv_seek_done[r.drive_sel]) begin
         next_r.seek_run = 1'b0;
      end
      // drive-level errors; seek error and bad cylinder both force a recalibrate
      if (seek_tmo || i_drv_cyl_illegal) begin
         next_r.ill_addr = 1'b1;
         next_r.recal = 1'b1;
         next_r.seek_run = 1'b0;
      end
      if (i_drv_seek_error) begin
         next_r.recal = 1'b1;
         next_r.seek_done[r.drive_sel] = 1'b1;
      end
      next_r.seek_done = next_r.seek_done | i_drv_seek_done;
      // transfer sequencing
      case (r.state)
         dcr_pkg::dcr_st_idle: begin
            if (start_ok) begin
               next_r.state = dcr_pkg::dcr_st_check;
               next_r.done = 1'b0;
               next_r.err = 8'h00;
               next_r.fault_lat = 1'b0;
               next_r.retried = 1'b0;
               if (r.cmd == dcr_pkg::dcr_write && i_drv_wprot) begin
                  next_r.ill_cmd = 1'b1;
               end
            end
         end
         dcr_pkg::dcr_st_check: begin
            // caught before the sector engine is released
            if (r.surf > `DCR_MAX_SURFACE || r.sect > `DCR_MAX_SECTOR) begin
               next_r.err[0] = 1'b1;
               fin = 1'b1;
            end else begin
               next_r.state = dcr_pkg::dcr_st_xfer;
            end
         end
         dcr_pkg::dcr_st_xfer: begin
            // prompt terminations leave the position on the failing sector
            if (i_bad_sector || i_hdr_cyl_mismatch || i_hdr_surf_mismatch || xfer_tmo
                  || i_fifo_late || (|i_drv_fault)) begin
               next_r.err[2] = i_bad_sector;
               next_r.err[3] = i_hdr_cyl_mismatch;
               next_r.err[4] = i_hdr_surf_mismatch;
               next_r.err[6] = xfer_tmo;
               next_r.err[7] = i_fifo_late;
               if (|i_drv_fault) begin
                  next_r.fault_lat = 1'b1;
                  next_r.fault_clr = 1'b1;
               end
               fin = 1'b1;
            end else if (i_sector_done) begin
               if (i_ecc_error && is_read_cmd(r.cmd) && !r.retried) begin
                  next_r.retried = 1'b1;
                  next_r.retry = 1'b1;
               end else begin
                  adv = 1'b1;
                  next_r.retried = 1'b0;
                  if (i_ecc_error) begin
                     next_r.err[1] = 1'b1;
                     fin = 1'b1;
                  end else if (i_verify_mismatch && r.cmd == dcr_pkg::dcr_verify) begin
                     next_r.err[5] = 1'b1;
                     fin = 1'b1;
                  end else if (r.cnt == 5'h1F) begin
                     fin = 1'b1;
                  end
               end
            end
         end
         default: begin
            next_r.state = dcr_pkg::dcr_st_idle;
         end
      endcase
      // step to the next sector; count is two's complement so it climbs toward zero
      if (adv) begin
         next_r.cnt = r.cnt + 5'h01;
         if (r.sect >= `DCR_MAX_SECTOR) begin
            next_r.sect = 5'h00;
            next_r.surf = r.surf + 5'h01;
         end else begin
            next_r.sect = r.sect + 5'h01;
         end
      end
      if (fin) begin
         next_r.state = dcr_pkg::dcr_st_idle;
         next_r.done = 1'b1;
         next_r.abort = (|next_r.err) || next_r.fault_lat;
      end
      // data-in read-back, alternate modes chosen by the held command
      if (i_in_ctrl_status_instr) begin
         case (r.cmd)
            dcr_pkg::dcr_alt1: next_r.data_in = r.dma_addr;
            dcr_pkg::dcr_alt2: next_r.data_in = i_ecc_residue[31:16];
            default: next_r.data_in = ctl_word(r, i_drv_fault);
         endcase
      end else if (i_in_drive_status_instr) begin
         case (r.cmd)
            dcr_pkg::dcr_alt1: next_r.data_in = {12'h000, r.ext_addr};
            dcr_pkg::dcr_alt2: next_r.data_in = i_ecc_residue[15:0];
            default: begin
               next_r.data_in = `DCR_RST_WORD;
               next_r.data_in[`DCR_DS_RESERVED] = i_drv_reserved;
               next_r.data_in[`DCR_DS_READY] = i_drv_ready;
               next_r.data_in[`DCR_DS_BUSY] = i_drv_busy;
               next_r.data_in[`DCR_DS_WPROT] = i_drv_wprot;
               next_r.data_in[`DCR_DS_ILL_ADDR] = r.ill_addr;
               next_r.data_in[`DCR_DS_ILL_CMD] = r.ill_cmd;
               next_r.data_in[`DCR_DS_FAULT] = i_drv_fault;
               next_r.data_in[`DCR_DS_ERR] = r.ill_addr || r.ill_cmd || (|i_drv_fault);
            end
         endcase
      end else if (i_in_sector_position_instr) begin
         next_r.data_in = {1'b0, r.surf, r.sect, r.cnt};
      end
   end

   // single state register; reset stands in for the I/O reset instruction
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign o_data_in = r.data_in;
   assign o_done = r.done;
   assign o_control_full = r.ctl_full;
   assign o_command = r.cmd;
   assign o_drive_sel = r.drive_sel;
   assign o_dma_addr = r.dma_addr;
   assign o_upper_address_bits = r.ext_addr;
   assign o_cylinder = r.cyl;
   assign o_surface = r.surf;
   assign o_sector = r.sect;
   assign o_count = r.cnt;
   assign o_drv_cmd_start = r.drv_start;
   assign o_xfer_abort = r.abort;
   assign o_ecc_retry = r.retry;
   assign o_fault_clear = r.fault_clr;
   assign o_recalibrate = r.recal;

   default clocking dcr_cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   // guards on the register loads and terminations
   a_ma_busy_hold: assert property (o_busy && i_out_mem_addr_instr |=> $stable(o_dma_addr))
      else $error("address changed while busy");
   a_ma_ext_load: assert property (!o_busy && i_out_mem_addr_instr |=>
      o_dma_addr == $past(i_accumulator) && o_upper_address_bits == $past(r.aux))
      else $error("address or extended address not loaded");
   a_cyl_load: assert property (i_out_cyl_or_sector_instr && r.cmd == dcr_pkg::dcr_seek
      && !r.ctl_full |=> o_cylinder == $past(i_accumulator[9:0]))
      else $error("cylinder not loaded");
   a_ssc_busy_hold: assert property (o_busy && i_out_cyl_or_sector_instr
      && r.cmd != dcr_pkg::dcr_seek && !i_sector_done |=> $stable({o_surface, o_sector}))
      else $error("position changed while busy");
   a_err_summary: assert property (i_in_ctrl_status_instr && r.cmd != dcr_pkg::dcr_alt1
      && r.cmd != dcr_pkg::dcr_alt2 |=>
      o_data_in[0] == ($past(|r.err) || $past(r.fault_lat) || $past(|i_drv_fault)))
      else $error("error summary wrong");
   a_illegal_end: assert property (r.state == dcr_pkg::dcr_st_check
      && o_surface > `DCR_MAX_SURFACE |=> !o_busy && o_done && r.err[0] ##1 !o_busy)
      else $error("illegal address not ended");
   a_timeout_end: assert property (xfer_tmo && r.state == dcr_pkg::dcr_st_xfer |=>
      r.err[6] && o_done && !o_busy && $stable(o_sector))
      else $error("timeout not ended");
   a_cf_pulse: assert property (i_out_cyl_or_sector_instr && i_io_pulse_control
      && !r.ctl_full && !i_drv_cmd_taken |=> o_control_full && o_drv_cmd_start)
      else $error("control full not set");
   a_ecc_retry: assert property (r.state == dcr_pkg::dcr_st_xfer && i_sector_done
      && i_ecc_error && is_read_cmd(r.cmd) && !r.retried && !(|i_drv_fault) && !xfer_tmo
      && !i_fifo_late && !i_bad_sector && !i_hdr_cyl_mismatch && !i_hdr_surf_mismatch
      |=> o_ecc_retry && o_busy && $stable(o_sector))
      else $error("ecc retry missing");

   c_normal_end: cover property (o_busy ##1 !o_busy && o_done && !o_xfer_abort);
   c_ecc_retry: cover property (o_ecc_retry);
   c_alt2_read: cover property (r.cmd == dcr_pkg::dcr_alt2 && i_in_ctrl_status_instr);
   c_seek_start: cover property (seek_go);
endmodule // dcr_io_regs

// *** testbench/dcr_cpu_model.sv ***
// Purpose: processor side that issues the programmed-I/O instructions
// Assumes: one strobe per instruction, read data settled one edge after the strobe
// Notes: strobe index 0 cmd, 1 address, 2 cylinder/sector, 3 start, 4-6 the three reads
`timescale 1ns/10ps
module dcr_cpu_model (
   input wire logic i_ref_clk,
   input wire logic [15:0] i_data_in,
   output logic [15:0] o_accumulator,
   output logic [6:0] o_strobe,
   output logic o_io_pulse_control
);
   // quiet bus at time zero
   initial begin
      o_accumulator = 16'h0000;
      o_strobe = 7'h00;
      o_io_pulse_control = 1'b0;
   end

   // one instruction, held over exactly one taking edge
   task automatic op(input int k, input logic [15:0] ac, input logic p,
                     output logic [15:0] rd);
      @(posedge i_ref_clk);
      #1;
      o_accumulator = ac;
      o_io_pulse_control = p;
      o_strobe[k] = 1'b1;
      @(posedge i_ref_clk);
      #1;
      rd = i_data_in;
      o_strobe = 7'h00;
      o_io_pulse_control = 1'b0;
      o_accumulator = ~ac; // a released bus must not look like the last word
   endtask
endmodule // dcr_cpu_model

// *** testbench/test_disc_ctrl_io_register_interface.sv ***
// Purpose: self-checking bench for the disc controller register interface
// Assumes: timeouts shortened to 40 and 20 cycles
// Notes: ev drives the sector engine and drive events as one-cycle pulses
`timescale 1ns/10ps
module test_disc_ctrl_io_register_interface;
   logic i_ref_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [15:0] acc, din, rd, dma;
   logic [6:0] stb;
   logic [13:0] ev = 14'h0000;
   logic pls, busy, done, cfull, dst, abt, rty, fclr, rcl;
   logic rsv = 1'b0, rdy = 1'b0, dbz = 1'b0, wp = 1'b0;
   logic [2:0] flt = 3'h0;
   logic [4:0] seen = 5'h00;
   logic [9:0] cyl;
   logic [3:0] upper;
   logic [3:0] cmd;
   logic [1:0] dsel;
   logic [14:0] pos;
   int errors = 0, n_tests = 0;
   always #10 i_ref_clk = ~i_ref_clk;
   // pulses are caught sticky so a single-cycle output is never missed
   always @(posedge i_ref_clk) seen <= seen | {rcl, fclr, rty, abt, dst};

   dcr_cpu_model cpu (.i_ref_clk(i_ref_clk), .i_data_in(din), .o_accumulator(acc),
      .o_strobe(stb), .o_io_pulse_control(pls));
   dcr_io_regs #(.XFER_TMO_CYC(40), .SEEK_TMO_CYC(20)) dut (.i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n), .i_accumulator(acc), .i_out_cmd_drive_instr(stb[0]),
      .i_out_mem_addr_instr(stb[1]), .i_out_cyl_or_sector_instr(stb[2]),
      .i_io_pulse_control(pls), .i_io_start_control(stb[3]),
      .i_in_ctrl_status_instr(stb[4]), .i_in_drive_status_instr(stb[5]),
      .i_in_sector_position_instr(stb[6]), .i_drv_cmd_taken(ev[7]),
      .i_drv_seek_done(ev[11:8]), .i_drv_reserved(rsv), .i_drv_ready(rdy),
      .i_drv_busy(dbz), .i_drv_wprot(wp), .i_drv_fault(flt), .i_drv_cyl_illegal(ev[12]),
      .i_drv_seek_error(ev[13]), .i_sector_done(ev[0]), .i_ecc_error(ev[1]),
      .i_verify_mismatch(ev[2]), .i_bad_sector(ev[3]), .i_hdr_cyl_mismatch(ev[4]),
      .i_hdr_surf_mismatch(ev[5]), .i_fifo_late(ev[6]), .i_ecc_residue(32'h12345678),
      .o_data_in(din), .o_busy(busy), .o_done(done), .o_control_full(cfull),
      .o_command(cmd), .o_drive_sel(dsel), .o_dma_addr(dma), .o_upper_address_bits(upper),
      .o_cylinder(cyl), .o_surface(pos[14:10]), .o_sector(pos[9:5]), .o_count(pos[4:0]),
      .o_drv_cmd_start(dst),
      .o_xfer_abort(abt), .o_ecc_retry(rty), .o_fault_clear(fclr), .o_recalibrate(rcl));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // a pulse launched at one edge lands in seen only at the following edge
   task automatic saw(input int k);
      @(posedge i_ref_clk);
      #1;
      chk({15'h0, seen[k]}, 16'h0001);
      seen = 5'h00;
   endtask
   task automatic evt(input logic [13:0] v);
      @(posedge i_ref_clk);
      #1;
      ev = v;
      @(posedge i_ref_clk);
      #1;
      ev = 14'h0000;
   endtask
   task automatic io(input int k, input logic [15:0] ac);
      cpu.op(k, ac, 1'b0, rd);
   endtask
   // command, position word, start; returns one edge after the check state, in transfer if the position is legal
   task automatic xfer(input logic [3:0] c, input logic [15:0] pos);
      io(0, {5'h00, c, 7'h00});
      io(2, pos);
      io(3, 16'h0000);
      @(posedge i_ref_clk);
      #1;
      seen = 5'h00;
   endtask
   task automatic complete_run;
      if (errors == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // watchdog against a hung handshake
   initial begin
      #60000;
      errors++;
      complete_run();
   end

   // main sequence
   initial begin
      logic [15:0] st [4];
      int eb [4];
      st = '{16'h0040, 16'h0020, 16'h0010, 16'h0002};
      eb = '{3, 4, 5, 6};
      repeat (4) @(posedge i_ref_clk);
      #1;
      i_rst_n = 1'b1;
      io(4, 16'h0000);
      chk(rd, 16'h0000);
      io(0, 16'h0120); // seek, drive 1
      chk({10'h000, dsel, cmd}, 16'h0012);
      cpu.op(2, 16'h0155, 1'b1, rd);
      chk({6'h00, cyl}, 16'h0155);
      chk({15'h0, cfull}, 16'h0001);
      saw(0);
      io(4, 16'h0000);
      chk(rd, 16'h8000);
      cpu.op(2, 16'h02AA, 1'b1, rd);
      chk({6'h00, cyl}, 16'h0155);
      evt(14'h0280);
      io(4, 16'h0000);
      chk(rd, 16'h1000);
      io(0, 16'h048A);
      io(1, 16'hBEEF);
      chk(dma, 16'hBEEF);
      chk({12'h000, upper}, 16'h000A);
      io(4, 16'h0000);
      chk(rd, 16'hBEEF);
      io(5, 16'h0000);
      chk(rd, 16'h000A);
      io(0, 16'h0500);
      io(4, 16'h0000);
      chk(rd, 16'h1234);
      io(5, 16'h0000);
      chk(rd, 16'h5678);
      xfer(4'h0, 16'h0BFE);
      chk({15'h0, busy}, 16'h0001);
      io(1, 16'h1111);
      io(2, 16'h7FFF);
      chk(dma, 16'hBEEF);
      evt(14'h0001);
      io(6, 16'h0000);
      chk(rd, 16'h0C1F);
      evt(14'h0001);
      io(6, 16'h0000);
      chk(rd, 16'h0C20);
      chk({1'b0, pos}, 16'h0C20);
      io(4, 16'h0000);
      chk(rd, 16'h5000);
      xfer(4'h0, 16'h501F);
      io(4, 16'h0000);
      chk(rd, 16'h5101);
      saw(1);
      for (int i = 0; i < 4; i++) begin
         xfer(4'h0, 16'h009F);
         evt(14'h0001 << eb[i]);
         io(4, 16'h0000);
         chk(rd & 16'hBFFF, 16'h1001 | st[i]);
         io(6, 16'h0000);
         chk(rd, 16'h009F);
      end
      io(0, 16'h00A0); // recalibrate drive 1 after the cylinder error
      cpu.op(2, 16'h0000, 1'b1, rd);
      evt(14'h0080);
      xfer(4'h0, 16'h009F);
      repeat (45) @(posedge i_ref_clk);
      io(4, 16'h0000);
      chk(rd & 16'hBFFF, 16'h1005);
      xfer(4'h0, 16'h009E);
      evt(14'h0003);
      saw(2);
      io(6, 16'h0000);
      chk(rd, 16'h009E);
      evt(14'h0003);
      io(4, 16'h0000);
      chk(rd & 16'hBFFF, 16'h1081);
      io(6, 16'h0000);
      chk(rd, 16'h00BF);
      xfer(4'hC, 16'h009E);
      evt(14'h0005);
      io(4, 16'h0000);
      chk(rd, 16'h5009);
      io(6, 16'h0000);
      chk(rd, 16'h00BF);
      xfer(4'h0, 16'h009F);
      flt = 3'h1;
      repeat (3) @(posedge i_ref_clk);
      #1;
      saw(3);
      chk({14'h0, busy, done}, 16'h0001);
      {rsv, rdy, dbz, wp} = 4'hF;
      io(5, 16'h0000);
      chk(rd, 16'h5A09);
      flt = 3'h0;
      xfer(4'hE, 16'h009F);
      io(5, 16'h0000);
      chk(rd & 16'h00C1, 16'h0041);
      repeat (45) @(posedge i_ref_clk);
      #1;
      {rsv, rdy, dbz, wp} = 4'h4;
      io(0, 16'h0100);
      cpu.op(2, 16'h0001, 1'b1, rd);
      evt(14'h0080);
      seen = 5'h00;
      repeat (25) @(posedge i_ref_clk);
      io(5, 16'h0000);
      chk(rd & 16'h0081, 16'h0081);
      saw(4);
      evt(14'h2000);
      saw(4);
      io(4, 16'h0000);
      chk(rd & 16'h3C00, 16'h3000);
      io(0, 16'h0100);
      evt(14'h1000);
      io(5, 16'h0000);
      chk(rd & 16'h0081, 16'h0081);
      complete_run();
   end
endmodule // test_disc_ctrl_io_register_interface
